// ---- verilog/cpu_status_pkg.sv ----
// Constants, operation codes and state layout for the status and configuration register bank
package cpu_status_pkg;

	// ----------------------------------------------------------------
	// Data address map
	// ----------------------------------------------------------------
	localparam int                  FILE_ADDR_W     = 5;
	localparam logic [4:0]          STATUS_ADDR     = 5'h03;

	// ----------------------------------------------------------------
	// Status register field positions
	// ----------------------------------------------------------------
	localparam int                  BIT_WAKE        = 7;
	localparam int                  BIT_UNUSED      = 6;
	localparam int                  BIT_PAGE        = 5;
	localparam int                  BIT_EXPIRY      = 4;
	localparam int                  BIT_SLEEP       = 3;
	localparam int                  BIT_NULL        = 2;
	localparam int                  BIT_NIBBLE      = 1;
	localparam int                  BIT_CARRY       = 0;
	localparam int                  NIBBLE_MSB      = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic                WAKE_POR        = 1'b0;
	localparam logic                PAGE_POR        = 1'b0;
	localparam logic                EXPIRY_POR      = 1'b1;
	localparam logic                SLEEP_POR       = 1'b1;
	// Arithmetic flags are undefined at power-on; zero is used
	localparam logic                ARITH_POR       = 1'b0;
	localparam logic [7:0]          CONFIG_RESET    = 8'hff;
	localparam logic [7:0]          BYTE_ZERO       = 8'h00;

	// ----------------------------------------------------------------
	// Program memory paging
	// ----------------------------------------------------------------
	localparam int                  PAGE_WORDS      = 512;
	localparam int                  PROG_WORDS_DEF  = 1024;

	// ----------------------------------------------------------------
	// Flag-affecting operation classes issued by the core
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_SUB,
		OP_ROTR,
		OP_ROTL,
		OP_ZERO_ONLY
	} alu_op_type;

	// ----------------------------------------------------------------
	// Whole state of the register bank
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wake;
		logic       page;
		logic       expiry;
		logic       sleep;
		logic       null_res;
		logic       nibble;
		logic       carry;
		logic [7:0] config_val;
		logic [7:0] result;
		logic       result_valid;
	} bank_state_type;

endpackage : cpu_status_pkg

// ---- verilog/cpu_status_and_option_regs.sv ----
// Status register and write-only timer/watchdog configuration register of the processor core
//
// Functional notes
// R1: Status register lives at data address 03h
// R2: Power-on: bits 7,5 zero; expiry, sleep one
// R3: Bit 7 set only by pin-change wake reset; code also loads it from status register writes
// R4: Expiry flag set by power-up, clear-watchdog, sleep
// R5: Watchdog time-out clears expiry flag
// R6: Add: nibble flag is carry out bit 3
// R7: Subtract: nibble flag is inverted nibble borrow
// R8: Nibble flag changes only on add, subtract; code also loads it from status register writes
// R9: Rotates load carry with shifted-out bit
// R10: Configuration register eight bits, never readable
// R11: Load instruction copies accumulator into configuration
// R12: Every reset sets configuration to all ones
// R13: Page bit selects upper 512-word program page
// R14: Flag results override writes to flag bits
// R15: Writes never alter expiry or sleep flags
// R16: Subtract: carry is inverted borrow out
// R17: Sleep flag: set power-up/clear-watchdog, cleared sleep
// R18: Null flag tracks zero result when affected
`timescale 1ns/10ps

module cpu_status_and_option_regs #(
	parameter int PROG_WORDS = cpu_status_pkg::PROG_WORDS_DEF
) (
	input  wire logic                                  sys_clk,
	input  wire logic                                  sys_rst,
	input  wire logic                                  clk_en,
	input  wire logic                                  other_reset,
	input  wire logic                                  reset_by_pin_wake,
	input  wire logic                                  watchdog_timeout,
	input  wire logic                                  watchdog_clear_instr,
	input  wire logic                                  sleep_instr,
	input  wire logic                                  option_load_instr,
	input  wire logic [7:0]                            w_value,
	input  wire logic [7:0]                            file_value,
	input  wire cpu_status_pkg::alu_op_type            alu_op,
	input  wire logic [7:0]                            file_wdata,
	input  wire logic                                  file_we,
	input  wire logic [cpu_status_pkg::FILE_ADDR_W-1:0] file_addr,
	output logic                                       status_sel,
	output logic [7:0]                                 status_rdata,
	output logic [7:0]                                 alu_result,
	output logic                                       alu_result_valid,
	output logic [7:0]                                 timer_prescale_config,
	output logic                                       program_page_select
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cpu_status_pkg::bank_state_type state_q;
	cpu_status_pkg::bank_state_type state_d;

	// ----------------------------------------------------------------
	// Flag arithmetic
	// ----------------------------------------------------------------
	logic [8:0] add_full;
	logic [4:0] add_nib;
	logic [8:0] sub_full;
	logic [4:0] sub_nib;
	logic [7:0] op_result;
	logic       op_carry;
	logic       op_nibble;
	logic       op_null;
	logic       hits_carry;
	logic       hits_nibble;
	logic       hits_null;
	logic       status_write;

	always_comb begin
		add_full    = {1'b0, w_value} + {1'b0, file_value};
		add_nib     = {1'b0, w_value[cpu_status_pkg::NIBBLE_MSB:0]}
			+ {1'b0, file_value[cpu_status_pkg::NIBBLE_MSB:0]};
		sub_full    = {1'b0, file_value} - {1'b0, w_value};
		sub_nib     = {1'b0, file_value[cpu_status_pkg::NIBBLE_MSB:0]}
			- {1'b0, w_value[cpu_status_pkg::NIBBLE_MSB:0]};
		op_result   = file_wdata;
		op_carry    = state_q.carry;
		op_nibble   = state_q.nibble;
		hits_carry  = 1'b0;
		hits_nibble = 1'b0;
		hits_null   = 1'b0;
		unique case (alu_op)
			cpu_status_pkg::OP_ADD: begin
				op_result   = add_full[7:0];
				op_carry    = add_full[8];
				op_nibble   = add_nib[4];                            // R6
				hits_carry  = 1'b1;
				hits_nibble = 1'b1;                                  // R8
				hits_null   = 1'b1;
			end
			cpu_status_pkg::OP_SUB: begin
				op_result   = sub_full[7:0];
				// Borrow shows as the ninth bit of the difference
				op_carry    = ~sub_full[8];                          // R16
				op_nibble   = ~sub_nib[4];                           // R7
				hits_carry  = 1'b1;
				hits_nibble = 1'b1;                                  // R8
				hits_null   = 1'b1;
			end
			cpu_status_pkg::OP_ROTR: begin
				op_result   = {state_q.carry, file_value[7:1]};
				op_carry    = file_value[0];                         // R9
				hits_carry  = 1'b1;
			end
			cpu_status_pkg::OP_ROTL: begin
				op_result   = {file_value[6:0], state_q.carry};
				op_carry    = file_value[7];                         // R9
				hits_carry  = 1'b1;
			end
			cpu_status_pkg::OP_ZERO_ONLY: begin
				hits_null   = 1'b1;
			end
			cpu_status_pkg::OP_NONE: begin
				hits_null   = 1'b0;
			end
			default: begin
				hits_null   = 1'b0;
			end
		endcase
		op_null = (op_result == cpu_status_pkg::BYTE_ZERO);         // R18
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb begin
		status_sel   = (file_addr == cpu_status_pkg::STATUS_ADDR);   // R1
		status_write = file_we && status_sel;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (sys_rst) begin
			// Power-on reset
			state_d.wake         = cpu_status_pkg::WAKE_POR;         // R2
			state_d.page         = cpu_status_pkg::PAGE_POR;         // R2
			state_d.expiry       = cpu_status_pkg::EXPIRY_POR;       // R4
			state_d.sleep        = cpu_status_pkg::SLEEP_POR;        // R17
			state_d.null_res     = cpu_status_pkg::ARITH_POR;
			state_d.nibble       = cpu_status_pkg::ARITH_POR;
			state_d.carry        = cpu_status_pkg::ARITH_POR;
			state_d.config_val   = cpu_status_pkg::CONFIG_RESET;     // R12
			state_d.result       = cpu_status_pkg::BYTE_ZERO;
			state_d.result_valid = 1'b0;
		end else if (clk_en) begin
			if (other_reset) begin
				// Expiry and sleep keep their cause; the timeout pulse
				// that caused a watchdog reset still lands below
				state_d.wake         = reset_by_pin_wake;            // R3
				state_d.page         = cpu_status_pkg::PAGE_POR;
				state_d.config_val   = cpu_status_pkg::CONFIG_RESET; // R12
				state_d.result_valid = 1'b0;
			end else begin
				// Software write, then flag results on top of it
				if (status_write) begin
					state_d.wake = (hits_carry || hits_null) ? op_result[cpu_status_pkg::BIT_WAKE]
						: file_wdata[cpu_status_pkg::BIT_WAKE];
					state_d.page = (hits_carry || hits_null) ? op_result[cpu_status_pkg::BIT_PAGE]
						: file_wdata[cpu_status_pkg::BIT_PAGE];
					// Expiry and sleep bits of the written byte are dropped R15
					if (!hits_null) begin
						state_d.null_res = file_wdata[cpu_status_pkg::BIT_NULL];
					end
					if (!hits_nibble) begin
						state_d.nibble = (hits_carry) ? op_result[cpu_status_pkg::BIT_NIBBLE]
							: file_wdata[cpu_status_pkg::BIT_NIBBLE];
					end
					if (!hits_carry) begin
						state_d.carry = file_wdata[cpu_status_pkg::BIT_CARRY];
					end
				end
				if (hits_null) begin
					state_d.null_res = op_null;                      // R14
				end
				if (hits_nibble) begin
					state_d.nibble = op_nibble;                      // R14
				end
				if (hits_carry) begin
					state_d.carry = op_carry;                        // R14
				end
				if (option_load_instr) begin
					state_d.config_val = w_value;                    // R11
				end
				state_d.result       = op_result;
				state_d.result_valid = (alu_op != cpu_status_pkg::OP_NONE);
			end
			// Device events on expiry and sleep flags
			if (watchdog_clear_instr) begin
				state_d.expiry = 1'b1;                               // R4
				state_d.sleep  = 1'b1;                               // R17
			end
			if (sleep_instr) begin
				state_d.expiry = 1'b1;                               // R4
				state_d.sleep  = 1'b0;                               // R17
			end
			// A time-out outranks a same-cycle clear so it is never lost
			if (watchdog_timeout) begin
				state_d.expiry = 1'b0;                               // R5
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		state_q <= state_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		// Unimplemented bit 6 stays at the zero loaded here
		status_rdata                              = cpu_status_pkg::BYTE_ZERO;
		status_rdata[cpu_status_pkg::BIT_WAKE]    = state_q.wake;
		status_rdata[cpu_status_pkg::BIT_PAGE]    = state_q.page;
		status_rdata[cpu_status_pkg::BIT_EXPIRY]  = state_q.expiry;
		status_rdata[cpu_status_pkg::BIT_SLEEP]   = state_q.sleep;
		status_rdata[cpu_status_pkg::BIT_NULL]    = state_q.null_res;
		status_rdata[cpu_status_pkg::BIT_NIBBLE]  = state_q.nibble;
		status_rdata[cpu_status_pkg::BIT_CARRY]   = state_q.carry;
		alu_result            = state_q.result;
		alu_result_valid      = state_q.result_valid;
		// Only reaches the timer logic; no read path exists R10
		timer_prescale_config = state_q.config_val;
		// Small parts keep the bit as plain storage but never page with it
		program_page_select   = (PROG_WORDS > cpu_status_pkg::PAGE_WORDS) ? state_q.page : 1'b0; // R13
	end

endmodule : cpu_status_and_option_regs

// ---- dv/cpu_status_and_option_regs_props.sv ----
// Concurrent checks on the ports of the status and configuration register bank
`timescale 1ns/10ps
module cpu_status_and_option_regs_props (
	input wire logic                       sys_clk,
	input wire logic                       sys_rst,
	input wire logic                       clk_en,
	input wire logic                       other_reset,
	input wire logic                       watchdog_timeout,
	input wire logic                       watchdog_clear_instr,
	input wire logic                       sleep_instr,
	input wire logic                       option_load_instr,
	input wire logic [7:0]                 w_value,
	input wire logic [7:0]                 file_value,
	input wire cpu_status_pkg::alu_op_type alu_op,
	input wire logic                       file_we,
	input wire logic [4:0]                 file_addr,
	input wire logic                       status_sel,
	input wire logic [7:0]                 status_rdata,
	input wire logic [7:0]                 timer_prescale_config
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// Qualifiers
	// ----------------------------------------------------------------
	// An other reset swallows writes and ops, so every data rule waits for it to drop
	wire run = clk_en && !other_reset;
	wire nib_cy = ({1'b0, w_value[3:0]} + {1'b0, file_value[3:0]}) > 5'h0f;
	wire no_brw = file_value >= w_value;
	sequence s_add; run ##0 alu_op == cpu_status_pkg::OP_ADD; endsequence
	sequence s_sub; run ##0 alu_op == cpu_status_pkg::OP_SUB; endsequence
	chk_sel_decode: assert property (status_sel == (file_addr == 5'h03))
		else $error("status select decode wrong");
	chk_cfg_load: assert property (run && option_load_instr |=> timer_prescale_config == $past(w_value))
		else $error("config load wrong");
	chk_cfg_reset: assert property (clk_en && other_reset |=> timer_prescale_config == 8'hff)
		else $error("config not all ones after reset");
	chk_timeout_clears: assert property (clk_en && watchdog_timeout |=> !status_rdata[4])
		else $error("expiry flag not cleared");
	chk_clear_sets: assert property (clk_en && watchdog_clear_instr && !sleep_instr && !watchdog_timeout
		|=> status_rdata[4:3] == 2'b11)
		else $error("clear watchdog flags wrong");
	chk_sleep_sets: assert property (clk_en && sleep_instr && !watchdog_clear_instr && !watchdog_timeout
		|=> status_rdata[4:3] == 2'b10) else $error("sleep flags wrong");
	chk_add_nibble: assert property (s_add |=> status_rdata[1] == $past(nib_cy))
		else $error("add nibble carry wrong");
	chk_sub_borrow: assert property (s_sub |=> status_rdata[0] == $past(no_brw))
		else $error("subtract carry wrong");
	chk_flags_kept: assert property (run && !watchdog_timeout && !watchdog_clear_instr && !sleep_instr
		|=> $stable(status_rdata[4:3])) else $error("expiry or sleep flag changed");
	chk_nibble_kept: assert property (run && alu_op != cpu_status_pkg::OP_ADD && alu_op != cpu_status_pkg::OP_SUB
		&& !(file_we && status_sel) |=> $stable(status_rdata[1])) else $error("nibble flag changed");
endmodule : cpu_status_and_option_regs_props

// ---- dv/core_model.sv ----
// Instruction core stand-in that issues one instruction per call to the register bank
`timescale 1ns/10ps
module core_model (
	input  wire logic                  sys_clk,
	output logic                       clk_en,
	output logic                       other_reset,
	output logic                       reset_by_pin_wake,
	output logic                       watchdog_timeout,
	output logic                       watchdog_clear_instr,
	output logic                       sleep_instr,
	output logic                       option_load_instr,
	output logic [7:0]                 w_value,
	output logic [7:0]                 file_value,
	output cpu_status_pkg::alu_op_type alu_op,
	output logic [7:0]                 file_wdata,
	output logic                       file_we,
	output logic [4:0]                 file_addr
);
	// Released operands are inverted so a stale value never passes for a held one
	task automatic rel(input logic [7:0] w, f, d);
		{clk_en, option_load_instr, other_reset, reset_by_pin_wake, watchdog_timeout, watchdog_clear_instr,
			sleep_instr} <= 7'h40;
		alu_op <= cpu_status_pkg::OP_NONE;
		{w_value, file_value, file_wdata, file_we} <= {~w, ~f, ~d, 1'b0};
	endtask : rel
	// ----------------------------------------------------------------
	// Event bits: freeze, load, other reset, pin wake, timeout, clear, sleep
	// ----------------------------------------------------------------
	task automatic cyc(input logic [6:0] ev, input cpu_status_pkg::alu_op_type o, input logic [7:0] w, f, d,
		input logic we, input logic [4:0] a);
		@(posedge sys_clk);
		{clk_en, option_load_instr, other_reset, reset_by_pin_wake, watchdog_timeout, watchdog_clear_instr,
			sleep_instr} <= {~ev[6], ev[5:0]};
		alu_op <= o;
		{w_value, file_value, file_wdata, file_we, file_addr} <= {w, f, d, we, a};
		@(posedge sys_clk);
		rel(w, f, d);
	endtask : cyc
	initial begin
		rel(8'h00, 8'h00, 8'h00);
		file_addr <= 5'h00;
	end
endmodule : core_model

// ---- dv/cpu_status_and_option_regs_tb_top.sv ----
// Self-checking testbench of the status and configuration register bank
`timescale 1ns/10ps
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cpu_status_and_option_regs_tb_top;
	logic                       sys_clk;
	logic                       sys_rst;
	wire                        clk_en, other_reset, reset_by_pin_wake, watchdog_timeout, watchdog_clear_instr;
	wire                        sleep_instr, option_load_instr, file_we, status_sel, alu_result_valid;
	wire                        program_page_select;
	wire [7:0]                  w_value, file_value, file_wdata, status_rdata, alu_result, timer_prescale_config;
	wire [4:0]                  file_addr;
	cpu_status_pkg::alu_op_type alu_op;
	int                         fails = 0;
	int                         n_compared = 0;
	int                         cycles = 0;
	cpu_status_and_option_regs uut (.sys_clk, .sys_rst, .clk_en, .other_reset, .reset_by_pin_wake, .watchdog_timeout,
		.watchdog_clear_instr, .sleep_instr, .option_load_instr, .w_value, .file_value, .alu_op, .file_wdata, .file_we,
		.file_addr, .status_sel, .status_rdata, .alu_result, .alu_result_valid, .timer_prescale_config,
		.program_page_select);
	core_model core (.sys_clk, .clk_en, .other_reset, .reset_by_pin_wake, .watchdog_timeout, .watchdog_clear_instr,
		.sleep_instr, .option_load_instr, .w_value, .file_value, .alu_op, .file_wdata, .file_we, .file_addr);
	task automatic ex(input logic [6:0] ev, input cpu_status_pkg::alu_op_type o, input logic [7:0] w, f, d,
		input logic we = 1'b0, input logic [4:0] a = 5'h03);
		core.cyc(ev, o, w, f, d, we, a);
		#1;
	endtask : ex
	task automatic conclude;
		if (fails == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic t_write;
		ex(7'h00, cpu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'ha5, 1'b1);
		`CMP("wr", 8'hbd, status_rdata)
		`CMP("page", 1'b1, program_page_select)
		ex(7'h00, cpu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1, 5'h04);
		`CMP("other addr", 8'hbd, status_rdata)
		ex(7'h00, cpu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 1'b1);
		ex(7'h00, cpu_status_pkg::OP_ADD, 8'h00, 8'h00, 8'hff, 1'b1);
		`CMP("dest", 8'h1c, status_rdata)
	endtask : t_write
	task automatic t_arith;
		logic [8:0]  s;
		logic [7:0]  w, f;
		logic [15:0] av [4] = '{16'h0808, 16'h0f01, 16'hf010, 16'h0708};
		logic [15:0] sv [3] = '{16'h1001, 16'h0102, 16'h0505};
		for (int i = 0; i < 4; i++) begin
			{w, f} = av[i];
			s = w + f;
			ex(7'h00, cpu_status_pkg::OP_ADD, w, f, 8'h00);
			`CMP("sum", s[7:0], alu_result)
			`CMP("add", {s[7:0] == 8'h00, {1'b0, w[3:0]} + f[3:0] > 5'h0f, s[8]}, status_rdata[2:0])
		end
		for (int i = 0; i < 3; i++) begin
			{f, w} = sv[i];
			ex(7'h00, cpu_status_pkg::OP_SUB, w, f, 8'h00);
			`CMP("sub", {f == w, f[3:0] >= w[3:0], f >= w}, status_rdata[2:0])
		end
		ex(7'h00, cpu_status_pkg::OP_ROTR, 8'h00, 8'h01, 8'h00);
		`CMP("rotr", {8'h80, 3'b111}, {alu_result, status_rdata[2:0]})
		ex(7'h00, cpu_status_pkg::OP_ROTL, 8'h00, 8'h40, 8'h00);
		`CMP("rotl", {8'h81, 3'b110}, {alu_result, status_rdata[2:0]})
		`CMP("valid", 1'b1, alu_result_valid)
		ex(7'h00, cpu_status_pkg::OP_ZERO_ONLY, 8'h00, 8'h00, 8'h01);
		`CMP("nonzero", {8'h01, 3'b010}, {alu_result, status_rdata[2:0]})
		ex(7'h00, cpu_status_pkg::OP_ZERO_ONLY, 8'h00, 8'h00, 8'h00);
		`CMP("zero", {8'h00, 3'b110}, {alu_result, status_rdata[2:0]})
	endtask : t_arith
	task automatic t_events;
		logic [6:0] ev [5] = '{7'h02, 7'h01, 7'h04, 7'h06, 7'h02};
		logic [1:0] xp [5] = '{2'b11, 2'b10, 2'b00, 2'b01, 2'b11};
		for (int i = 0; i < 5; i++) begin
			ex(ev[i], cpu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h00);
			`CMP("events", xp[i], status_rdata[4:3])
		end
	endtask : t_events
	task automatic t_config;
		ex(7'h20, cpu_status_pkg::OP_NONE, 8'h5a, 8'h00, 8'h00);
		`CMP("load", 8'h5a, timer_prescale_config)
		ex(7'h60, cpu_status_pkg::OP_NONE, 8'hc3, 8'h00, 8'h00);
		`CMP("frozen", 8'h5a, timer_prescale_config)
		ex(7'h38, cpu_status_pkg::OP_NONE, 8'h12, 8'h00, 8'h00);
		`CMP("cfg rst", 8'hff, timer_prescale_config)
		`CMP("wake", 2'b10, {status_rdata[7], program_page_select})
		ex(7'h10, cpu_status_pkg::OP_NONE, 8'h00, 8'h00, 8'h00);
		`CMP("no wake", 1'b0, status_rdata[7])
	endtask : t_config
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		sys_rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		`CMP("por", {8'h18, 8'hff}, {status_rdata, timer_prescale_config})
		t_write();
		t_arith();
		t_events();
		t_config();
		conclude();
	end
endmodule : cpu_status_and_option_regs_tb_top
bind cpu_status_and_option_regs cpu_status_and_option_regs_props props (.sys_clk, .sys_rst, .clk_en, .other_reset,
	.watchdog_timeout, .watchdog_clear_instr, .sleep_instr, .option_load_instr, .w_value, .file_value, .alu_op,
	.file_we, .file_addr, .status_sel, .status_rdata, .timer_prescale_config);
